// ---- core/wake_flags_pkg.sv ----
// Shared constants and carrier types for the status flag bank
`default_nettype none
package wake_flags_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] SYS_FLAGS_OFFSET = 8'h1D;
  localparam logic [7:0] WAKE_FLAGS_OFFSET = 8'h1E;

  // Reset values and implemented-bit masks
  localparam logic [7:0] SYS_FLAGS_RESET = 8'h00;
  localparam logic [7:0] WAKE_FLAGS_RESET = 8'h00;
  localparam logic [7:0] SYS_FLAGS_MASK = 8'h3F;
  localparam logic [7:0] WAKE_FLAGS_MASK = 8'h1F;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Field positions, system-state register
  localparam int TRANS_REJECT_BIT = 5;
  localparam int LP_ENTRY_FAIL_BIT = 4;
  localparam int ERR_MISS_BIT = 3;
  localparam int FWD_ERR_BIT = 2;
  localparam int WWD_ERR_BIT = 1;
  localparam int CFG_ERR_BIT = 0;

  // Field positions, wake-cause register
  localparam int SERIAL_ROUSE_BIT = 4;
  localparam int TIMER_ROUSE_BIT = 3;
  localparam int CURRENT_ROUSE_BIT = 2;
  localparam int ACTIVATION_ROUSE_BIT = 1;
  localparam int PIN_ROUSE_BIT = 0;

  // Flip-flops in each clock-crossing synchroniser
  localparam int SYNC_DEPTH = 2;

  // One register access handed from the link domain to the core domain
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } link_req_type;

  // Field order matches bits 5..0 of the system-state register
  typedef struct packed {
    logic transition_request_rejected;
    logic low_power_entry_failed;
    logic mcu_error_signal_missed;
    logic functional_watchdog_error;
    logic window_watchdog_error;
    logic protected_config_double_error;
  } sys_event_type;

  // Field order matches bits 4..0 of the wake-cause register
  typedef struct packed {
    logic serial_command_rouse;
    logic timer_rouse;
    logic load_current_threshold_rouse;
    logic activation_input;
    logic external_rouse_pin;
  } wake_event_type;

endpackage
`default_nettype wire

// ---- core/flag_link_port.sv ----
// Link-clock side of the register port: takes one access and hands it to the core domain
`default_nettype none
module flag_link_port
  import wake_flags_pkg::*;
#(
  parameter int SYNC_STAGES = SYNC_DEPTH
) (
  // Link clock and reset
  input wire logic link_clk_in,
  input wire logic link_rstn_in,
  // Link-side access
  input wire logic link_wr_in,
  input wire logic link_rd_in,
  input wire logic [7:0] link_addr_in,
  input wire logic [7:0] link_wdata_in,
  output logic [7:0] link_rdata_out,
  output logic link_done_out,
  output logic link_busy_out,
  // Toward the core domain
  output link_req_type req_out,
  output logic req_toggle_out,
  input wire logic ack_toggle_in,
  input wire logic [7:0] core_rdata_in
);

  // Refused at elaboration: a single stage would let a metastable value reach the compare
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  typedef enum logic [1:0] {
    IDLE = 2'b01,
    WAIT = 2'b10
  } link_state_type;

  link_state_type state_r, state_nxt;
  link_req_type req_r, req_nxt;
  logic req_tgl_r, req_tgl_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  logic [SYNC_STAGES:0] ack_sync_r;
  logic ack_seen;

  // Last stage compared with an extra copy; the first stage feeds only the second
  assign ack_seen = ack_sync_r[SYNC_STAGES] ^ ack_sync_r[SYNC_STAGES-1];

  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    req_tgl_nxt = req_tgl_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    unique case (state_r)
      IDLE: begin
        // Request payload is frozen while waiting, so the core may sample it freely
        if (link_wr_in || link_rd_in) begin
          req_nxt.wr = link_wr_in;
          req_nxt.addr = link_addr_in;
          req_nxt.data = link_wdata_in;
          req_tgl_nxt = ~req_tgl_r;
          state_nxt = WAIT;
        end
      end
      WAIT: begin
        // Core read data has been stable since the acknowledge toggled, on the same core edge that registered it
        if (ack_seen) begin
          rdata_nxt = core_rdata_in;
          done_nxt = 1'b1;
          state_nxt = IDLE;
        end
      end
      default: begin
        state_nxt = IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk_in) begin
    if (!link_rstn_in) begin
      state_r <= IDLE;
      req_r <= '0;
      req_tgl_r <= 1'b0;
      rdata_r <= 8'h00;
      done_r <= 1'b0;
      ack_sync_r <= '0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      req_tgl_r <= req_tgl_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      ack_sync_r <= {ack_sync_r[SYNC_STAGES-1:0], ack_toggle_in};
    end
  end

  assign link_rdata_out = rdata_r;
  assign link_done_out = done_r;
  assign link_busy_out = (state_r == WAIT);
  assign req_out = req_r;
  assign req_toggle_out = req_tgl_r;

endmodule
`default_nettype wire

// ---- core/system_wake_status_flags.sv ----
// System-state and wake-cause sticky flag registers with a link-clock register port
//
// Operation
// - A refused state-change request through the request register pair sets system-state bit 5.
// - An aborted low-power entry sets system-state bit 4.
// - A missed controller error signal sets system-state bit 3 only while error recovery is on.
// - A functional watchdog error sets system-state bit 2, which holds until cleared by software.
// - A window watchdog error sets system-state bit 1, which holds until cleared by software.
// - A protected configuration double-bit error sets system-state bit 0 for software to inspect.
// - Writing one to an implemented flag clears it and writing zero leaves it unchanged.
// - Leaving sleep on a serial go-to-active command sets wake-cause bit 4.
// - A wake-timer wakeup or a standby exit on timer expiry sets wake-cause bit 3.
// - A wakeup from the controller-supply current monitor sets wake-cause bit 2.
// - A wakeup or failsafe/standby exit caused by the activation input sets wake-cause bit 1.
// - A wakeup or failsafe/standby exit caused by the external wake pin sets wake-cause bit 0.
// - The wake-cause register resets to zero and its unused upper bits read zero and ignore writes.
// - Any system-state flag being set raises the platform summary indication.
// - The rouse summary indication is raised only when leaving sleep with an interrupt.
`default_nettype none
module system_wake_status_flags
  import wake_flags_pkg::*;
#(
  parameter int SYNC_STAGES = SYNC_DEPTH
) (
  // Core clock, reset and enable
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  input wire logic CLK_EN_IN,
  // Event pulses from device logic on the core clock
  input wire sys_event_type SYS_EVENT_IN,
  input wire wake_event_type WAKE_EVENT_IN,
  input wire logic ERROR_RECOVERY_ON_IN,
  input wire logic ROUSE_IRQ_ON_EXIT_IN,
  // Register port on the link clock
  input wire logic LINK_CLK_IN,
  input wire logic LINK_RSTN_IN,
  input wire logic LINK_WR_IN,
  input wire logic LINK_RD_IN,
  input wire logic [7:0] LINK_ADDR_IN,
  input wire logic [7:0] LINK_WDATA_IN,
  output logic [7:0] LINK_RDATA_OUT,
  output logic LINK_DONE_OUT,
  output logic LINK_BUSY_OUT,
  // Flag state and summary indications
  output logic [7:0] SYS_FLAGS_OUT,
  output logic [7:0] WAKE_FLAGS_OUT,
  output logic PLATFORM_SUMMARY_OUT,
  output logic ROUSE_SUMMARY_OUT
);

  // Refused at elaboration: a single stage would let a metastable value reach the compare
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
    addr_is = (addr == offset);
  endfunction

  // ---------------------------------------------------------------------------
  // Link-clock access port
  // ---------------------------------------------------------------------------
  link_req_type link_req;
  logic link_req_toggle;
  logic ack_tgl_r, ack_tgl_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  flag_link_port #(
    .SYNC_STAGES(SYNC_STAGES)
  ) u_link (
    .link_clk_in(LINK_CLK_IN),
    .link_rstn_in(LINK_RSTN_IN),
    .link_wr_in(LINK_WR_IN),
    .link_rd_in(LINK_RD_IN),
    .link_addr_in(LINK_ADDR_IN),
    .link_wdata_in(LINK_WDATA_IN),
    .link_rdata_out(LINK_RDATA_OUT),
    .link_done_out(LINK_DONE_OUT),
    .link_busy_out(LINK_BUSY_OUT),
    .req_out(link_req),
    .req_toggle_out(link_req_toggle),
    .ack_toggle_in(ack_tgl_r),
    .core_rdata_in(rdata_r)
  );

  // ---------------------------------------------------------------------------
  // Request crossing into the core domain
  // ---------------------------------------------------------------------------
  logic [SYNC_STAGES:0] req_sync_r;
  logic req_seen;

  // Only the last two stages are compared; stage zero feeds stage one alone
  assign req_seen = req_sync_r[SYNC_STAGES] ^ req_sync_r[SYNC_STAGES-1];

  // ---------------------------------------------------------------------------
  // Flag registers
  // ---------------------------------------------------------------------------
  logic [7:0] sys_flags_r, sys_flags_nxt;
  logic [7:0] wake_flags_r, wake_flags_nxt;
  logic [7:0] sys_set, wake_set;
  logic [7:0] sys_clr, wake_clr;
  logic platform_r, platform_nxt;
  logic rouse_r, rouse_nxt;

  always_comb begin
    sys_set = 8'h00;
    sys_set[TRANS_REJECT_BIT] = SYS_EVENT_IN.transition_request_rejected;
    sys_set[LP_ENTRY_FAIL_BIT] = SYS_EVENT_IN.low_power_entry_failed;
    // Ignored outright while recovery is off, so the flag cannot set late
    sys_set[ERR_MISS_BIT] = SYS_EVENT_IN.mcu_error_signal_missed & ERROR_RECOVERY_ON_IN;
    sys_set[FWD_ERR_BIT] = SYS_EVENT_IN.functional_watchdog_error;
    sys_set[WWD_ERR_BIT] = SYS_EVENT_IN.window_watchdog_error;
    sys_set[CFG_ERR_BIT] = SYS_EVENT_IN.protected_config_double_error;

    wake_set = 8'h00;
    wake_set[SERIAL_ROUSE_BIT] = WAKE_EVENT_IN.serial_command_rouse;
    wake_set[TIMER_ROUSE_BIT] = WAKE_EVENT_IN.timer_rouse;
    wake_set[CURRENT_ROUSE_BIT] = WAKE_EVENT_IN.load_current_threshold_rouse;
    wake_set[ACTIVATION_ROUSE_BIT] = WAKE_EVENT_IN.activation_input;
    wake_set[PIN_ROUSE_BIT] = WAKE_EVENT_IN.external_rouse_pin;
  end

  always_comb begin
    sys_clr = 8'h00;
    wake_clr = 8'h00;
    rdata_nxt = rdata_r;
    ack_tgl_nxt = ack_tgl_r;
    if (req_seen) begin
      ack_tgl_nxt = ~ack_tgl_r;
      // Read data shows the flags as they stood before this access
      if (addr_is(link_req.addr, SYS_FLAGS_OFFSET)) begin
        rdata_nxt = sys_flags_r;
      end else if (addr_is(link_req.addr, WAKE_FLAGS_OFFSET)) begin
        rdata_nxt = wake_flags_r;
      end else begin
        rdata_nxt = UNMAPPED_READ;
      end
      if (link_req.wr && addr_is(link_req.addr, SYS_FLAGS_OFFSET)) begin
        sys_clr = link_req.data & SYS_FLAGS_MASK;
      end
      if (link_req.wr && addr_is(link_req.addr, WAKE_FLAGS_OFFSET)) begin
        wake_clr = link_req.data & WAKE_FLAGS_MASK;
      end
    end
  end

  always_comb begin
    // Set is applied after clear so a coincident event survives
    sys_flags_nxt = ((sys_flags_r & ~sys_clr) | sys_set) & SYS_FLAGS_MASK;
    wake_flags_nxt = ((wake_flags_r & ~wake_clr) | wake_set) & WAKE_FLAGS_MASK;
    platform_nxt = |sys_set;
    rouse_nxt = (|wake_set) & ROUSE_IRQ_ON_EXIT_IN;
  end

  // Clock enable low freezes everything here; events offered meanwhile are not seen
  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      sys_flags_r <= SYS_FLAGS_RESET;
      wake_flags_r <= WAKE_FLAGS_RESET;
      platform_r <= 1'b0;
      rouse_r <= 1'b0;
      rdata_r <= 8'h00;
      ack_tgl_r <= 1'b0;
      req_sync_r <= '0;
    end else if (CLK_EN_IN) begin
      sys_flags_r <= sys_flags_nxt;
      wake_flags_r <= wake_flags_nxt;
      platform_r <= platform_nxt;
      rouse_r <= rouse_nxt;
      rdata_r <= rdata_nxt;
      ack_tgl_r <= ack_tgl_nxt;
      req_sync_r <= {req_sync_r[SYNC_STAGES-1:0], link_req_toggle};
    end
  end

  assign SYS_FLAGS_OUT = sys_flags_r;
  assign WAKE_FLAGS_OUT = wake_flags_r;
  assign PLATFORM_SUMMARY_OUT = platform_r;
  assign ROUSE_SUMMARY_OUT = rouse_r;

endmodule
`default_nettype wire

// ---- verification/system_wake_status_flags_asserts.sv ----
// Port-level checks for the status flag bank
`default_nettype none
module system_wake_status_flags_asserts
  import wake_flags_pkg::*;
(
  // Core domain
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  input wire logic CLK_EN_IN,
  input wire sys_event_type SYS_EVENT_IN,
  input wire wake_event_type WAKE_EVENT_IN,
  input wire logic ERROR_RECOVERY_ON_IN,
  input wire logic ROUSE_IRQ_ON_EXIT_IN,
  // Link domain
  input wire logic LINK_CLK_IN,
  input wire logic LINK_RSTN_IN,
  input wire logic LINK_DONE_OUT,
  // Flags and summaries
  input wire logic [7:0] SYS_FLAGS_OUT,
  input wire logic [7:0] WAKE_FLAGS_OUT,
  input wire logic PLATFORM_SUMMARY_OUT,
  input wire logic ROUSE_SUMMARY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // Missed-signal event only counts while recovery is on
  wire [5:0] sys_ev = SYS_EVENT_IN & {2'b11, ERROR_RECOVERY_ON_IN, 3'b111};

  sys_set_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    CLK_EN_IN |=> (SYS_FLAGS_OUT[5:0] & $past(sys_ev)) == $past(sys_ev)) else $error("system flag not set");
  miss_gate_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    !ERROR_RECOVERY_ON_IN && !SYS_FLAGS_OUT[3] |=> !SYS_FLAGS_OUT[3]) else $error("missed flag set while gated");
  wake_set_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    CLK_EN_IN |=> (WAKE_FLAGS_OUT[4:0] & $past(WAKE_EVENT_IN)) == $past(WAKE_EVENT_IN)) else $error("wake flag not set");
  no_rise_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    1'b1 |=> (SYS_FLAGS_OUT & ~$past(SYS_FLAGS_OUT) & {2'b00, ~$past(SYS_EVENT_IN)}) == 8'h00) else $error("flag rose alone");
  freeze_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    !CLK_EN_IN |=> $stable(SYS_FLAGS_OUT) && $stable(WAKE_FLAGS_OUT)) else $error("flags moved while frozen");
  plat_sum_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    CLK_EN_IN && (|(SYS_EVENT_IN & 6'h37)) |=> PLATFORM_SUMMARY_OUT) else $error("platform summary missing");
  rouse_sum_a: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
    CLK_EN_IN && ROUSE_IRQ_ON_EXIT_IN && (|WAKE_EVENT_IN) |=> ROUSE_SUMMARY_OUT) else $error("rouse summary missing");
  done_pulse_a: assert property (@(posedge LINK_CLK_IN) disable iff (!LINK_RSTN_IN)
    LINK_DONE_OUT |=> !LINK_DONE_OUT) else $error("done longer than one cycle");
endmodule
`default_nettype wire

// ---- verification/host_link_model.sv ----
// Host-side model of the link register port
`default_nettype none
module host_link_model (
  // Link clock and answer
  input wire logic clk_in,
  input wire logic done_in,
  input wire logic [7:0] rdata_in,
  // Request
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {wr_out, rd_out, addr_out, wdata_out} = 18'h00000;
  // Bus is scrambled after the take so a stale value never passes for a held one
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                        output logic ok);
    int n;
    @(posedge clk_in);
    wr_out <= w;
    rd_out <= !w;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk_in);
      ok = (done_in === 1'b1);
    end
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

// ---- verification/system_wake_status_flags_tb_top.sv ----
// Self-checking bench for the status flag bank
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("MISMATCH %0t %h vs %h", $time, g, e); end end
module system_wake_status_flags_tb_top
  import wake_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, ce, lclk, lrstn, recov, rirq, lwr, lrd, done, busy, psum, rsum, ok, pm, rm;
  logic [7:0] laddr, lwdata, lrdata, sysf, wakef, q, a, d;
  logic [31:0] r;
  sys_event_type sev;
  wake_event_type wev;
  int fails, n_tests, sm, wm, ex;
  system_wake_status_flags i_system_wake_status_flags (.MCLK_IN(mclk), .RSTN_IN(rstn), .CLK_EN_IN(ce),
    .SYS_EVENT_IN(sev), .WAKE_EVENT_IN(wev), .ERROR_RECOVERY_ON_IN(recov), .ROUSE_IRQ_ON_EXIT_IN(rirq),
    .LINK_CLK_IN(lclk), .LINK_RSTN_IN(lrstn), .LINK_WR_IN(lwr), .LINK_RD_IN(lrd), .LINK_ADDR_IN(laddr),
    .LINK_WDATA_IN(lwdata), .LINK_RDATA_OUT(lrdata), .LINK_DONE_OUT(done), .LINK_BUSY_OUT(busy),
    .SYS_FLAGS_OUT(sysf), .WAKE_FLAGS_OUT(wakef), .PLATFORM_SUMMARY_OUT(psum), .ROUSE_SUMMARY_OUT(rsum));
  host_link_model i_host_link_model (.clk_in(lclk), .done_in(done), .rdata_in(lrdata), .wr_out(lwr),
    .rd_out(lrd), .addr_out(laddr), .wdata_out(lwdata));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Offset start keeps the link clock out of phase with the core clock
  initial begin
    lclk = 1'b0;
    #5;
    forever #16 lclk = ~lclk;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {rstn, lrstn, ce, recov, rirq, sev, wev} = 16'h2000;
    {pm, rm} = 2'b00;
    {fails, n_tests, sm, wm} = '0;
    r = $urandom(93);
    repeat (5) @(negedge mclk);
    rstn = 1'b1;
    lrstn = 1'b1;
    `CHK({sysf, wakef}, 16'h0000)
    repeat (150) begin
      r = $urandom;
      ce = r[0] | r[1];
      recov = r[2];
      rirq = r[3];
      sev = r[9:4];
      wev = r[14:10];
      @(negedge mclk);
      if (ce) begin
        sm = sm | (sev & (recov ? 6'h3F : 6'h37));
        wm = wm | wev;
        // Summary pulses are registered state, so a frozen cycle keeps the last one
        pm = |(sev & (recov ? 6'h3F : 6'h37));
        rm = rirq & (|wev);
      end
      `CHK(sysf, 8'(sm))
      `CHK(wakef, 8'(wm))
      `CHK(rsum, rm)
      `CHK(psum, pm)
      sev = '0;
      wev = '0;
      ce = 1'b1;
      if (r[15]) begin
        a = (r[17:16] == 0) ? SYS_FLAGS_OFFSET : (r[17:16] == 1) ? WAKE_FLAGS_OFFSET : r[23:16];
        d = r[31:24];
        i_host_link_model.access(r[18], a, d, q, ok);
        `CHK(ok, 1'b1)
        if (!ok) test_done();
        ex = (a == SYS_FLAGS_OFFSET) ? sm : (a == WAKE_FLAGS_OFFSET) ? wm : 0;
        `CHK(q, 8'(ex))
        if (r[18] && a == SYS_FLAGS_OFFSET) sm = sm & ~d;
        if (r[18] && a == WAKE_FLAGS_OFFSET) wm = wm & ~d;
        @(negedge mclk);
        `CHK(busy, 1'b0)
        // Many enabled, event-free cycles have passed during the access
        {pm, rm} = 2'b00;
      end
    end
    // Events held through the whole access in the first two passes so the clear meets a set; the last two clear with no events
    recov = 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(negedge mclk);
      sev = {6{k < 2}};
      wev = {5{k < 2}};
      @(negedge mclk);
      i_host_link_model.access(1'b1, k[0] ? WAKE_FLAGS_OFFSET : SYS_FLAGS_OFFSET, 8'hFF, q, ok);
      `CHK(q, k[0] ? 8'h1F : 8'h3F)
      @(negedge mclk);
      `CHK(k[0] ? wakef : sysf, (k < 2) ? (k[0] ? 8'h1F : 8'h3F) : 8'h00)
    end
    test_done();
  end
endmodule
bind system_wake_status_flags system_wake_status_flags_asserts i_system_wake_status_flags_asserts (.MCLK_IN,
  .RSTN_IN, .CLK_EN_IN, .SYS_EVENT_IN, .WAKE_EVENT_IN, .ERROR_RECOVERY_ON_IN, .ROUSE_IRQ_ON_EXIT_IN, .LINK_CLK_IN,
  .LINK_RSTN_IN, .LINK_DONE_OUT, .SYS_FLAGS_OUT, .WAKE_FLAGS_OUT, .PLATFORM_SUMMARY_OUT, .ROUSE_SUMMARY_OUT);
`default_nettype wire
